/* bmcc_regs.sv */
// bridge misc control and clock strap registers with their consumers:
// arbiter priorities, completion accumulation, config retry timer
// assumes an APB master on pclk and side-band strobes synchronous to it

`timescale 1ns/1ps
`default_nettype none

module bmcc_regs #(
  parameter int unsigned CRT_CYC_0 = bmcc_pkg::CRT_US_0 * bmcc_pkg::CLK_MHZ,
  parameter int unsigned CRT_CYC_1 = bmcc_pkg::CRT_US_1 * bmcc_pkg::CLK_MHZ,
  parameter int unsigned CRT_CYC_2 = bmcc_pkg::CRT_US_2 * bmcc_pkg::CLK_MHZ,
  parameter int unsigned CRT_CYC_3 = bmcc_pkg::CRT_US_3 * bmcc_pkg::CLK_MHZ,
  parameter int unsigned CRT_CYC_4 = bmcc_pkg::CRT_US_4 * bmcc_pkg::CLK_MHZ,
  parameter int unsigned CRT_CYC_5 = bmcc_pkg::CRT_US_5 * bmcc_pkg::CLK_MHZ,
  parameter int unsigned CRT_CYC_6 = bmcc_pkg::CRT_US_6 * bmcc_pkg::CLK_MHZ,
  parameter int unsigned CRT_CYC_7 = bmcc_pkg::CRT_US_7 * bmcc_pkg::CLK_MHZ
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  bus_request_in_n,
  input  wire logic        internal_request,
  output logic      [4:0]  bus_grant,
  input  wire logic        pci_mode_in,
  input  wire logic        cpl_accum_start,
  input  wire logic        cpl_dword_valid,
  input  wire logic        cpl_last_in,
  output logic             cpl_xfer_go,
  input  wire logic        cfg1_issue,
  input  wire logic        cfg1_cpl_in,
  output logic             crs_return,
  output logic             short_term_cache_enable,
  output logic             pll_freq_select,
  input  wire logic        speed66_enable_in,
  output logic      [1:0]  bus_clock_out_speed
);

  // ****************************************************************
  // register storage
  // ****************************************************************
  logic       int_arb_en_q;
  logic [3:0] req_arb_en_q;
  logic       cache_en_q;
  logic       int_pri_q;
  logic [3:0] req_pri_q;
  logic [3:0] cpl_cnt_q;
  logic [2:0] crt_sel_q;
  logic       pll_sel_q;
  logic       clk_src_q;
  logic [2:0] clk_spd_q;

  logic [31:0] csr_view;
  logic [31:0] strap_view;
  logic        hit_csr;
  logic        hit_strap;
  logic        wr_fire;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  // fixed one-cycle access phase: pready rises the cycle after setup
  assign hit_csr   = (paddr == bmcc_pkg::MISC_CSR_OFFSET);
  assign hit_strap = (paddr == bmcc_pkg::CLK_STRAP_OFFSET);
  assign wr_fire   = psel & penable & pready & pwrite;

  // read views; unlisted bits stay zero
  always_comb begin
    csr_view = '0;
    csr_view[bmcc_pkg::INT_ARB_EN_BIT] = int_arb_en_q;
    csr_view[bmcc_pkg::REQ_ARB_EN_LSB +: 4] = req_arb_en_q;
    csr_view[bmcc_pkg::PAR_ERR_BIT] = 1'b1;
    csr_view[bmcc_pkg::CACHE_EN_BIT] = cache_en_q;
    csr_view[bmcc_pkg::INT_PRI_BIT] = int_pri_q;
    csr_view[bmcc_pkg::REQ_PRI_LSB +: 4] = req_pri_q;
    csr_view[bmcc_pkg::CPL_CNT_LSB +: bmcc_pkg::CPL_CNT_W] = cpl_cnt_q;
    csr_view[bmcc_pkg::CRT_LSB +: bmcc_pkg::CRT_SEL_W] = crt_sel_q;
    strap_view = '0;
    strap_view[bmcc_pkg::PLL_SEL_BIT] = pll_sel_q;
    strap_view[bmcc_pkg::CLK_SRC_BIT] = clk_src_q;
    strap_view[bmcc_pkg::CLK_SPD_LSB +: 3] = clk_spd_q;
  end

  // answer flops: ready, data and error are loaded in the setup cycle and appear in the cycle after it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && !penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= !(hit_csr || hit_strap);
      prdata  <= (!pwrite && hit_csr)   ? csr_view   :
                 (!pwrite && hit_strap) ? strap_view : 32'h0000_0000;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
  end

  // ****************************************************************
  // misc control/status register
  // ****************************************************************
  // parity behaviour bit is read-only here and reads as one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_arb_en_q <= bmcc_pkg::MISC_CSR_RESET[bmcc_pkg::INT_ARB_EN_BIT];
      req_arb_en_q <= bmcc_pkg::MISC_CSR_RESET[bmcc_pkg::REQ_ARB_EN_LSB +: 4];
      cache_en_q   <= bmcc_pkg::MISC_CSR_RESET[bmcc_pkg::CACHE_EN_BIT];
      int_pri_q    <= bmcc_pkg::MISC_CSR_RESET[bmcc_pkg::INT_PRI_BIT];
      req_pri_q    <= bmcc_pkg::MISC_CSR_RESET[bmcc_pkg::REQ_PRI_LSB +: 4];
      cpl_cnt_q    <= bmcc_pkg::MISC_CSR_RESET[bmcc_pkg::CPL_CNT_LSB +: 4];
      crt_sel_q    <= bmcc_pkg::MISC_CSR_RESET[bmcc_pkg::CRT_LSB +: 3];
    end else if (wr_fire && hit_csr) begin
      int_arb_en_q <= pwdata[bmcc_pkg::INT_ARB_EN_BIT];
      req_arb_en_q <= pwdata[bmcc_pkg::REQ_ARB_EN_LSB +: 4];
      cache_en_q   <= pwdata[bmcc_pkg::CACHE_EN_BIT];
      int_pri_q    <= pwdata[bmcc_pkg::INT_PRI_BIT];
      req_pri_q    <= pwdata[bmcc_pkg::REQ_PRI_LSB +: 4];
      cpl_cnt_q    <= pwdata[bmcc_pkg::CPL_CNT_LSB +: 4];
      crt_sel_q    <= pwdata[bmcc_pkg::CRT_LSB +: 3];
    end
  end

  // ****************************************************************
  // clock strap register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_sel_q <= bmcc_pkg::CLK_STRAP_RESET[bmcc_pkg::PLL_SEL_BIT];
      clk_src_q <= bmcc_pkg::CLK_STRAP_RESET[bmcc_pkg::CLK_SRC_BIT];
      clk_spd_q <= bmcc_pkg::CLK_STRAP_RESET[bmcc_pkg::CLK_SPD_LSB +: 3];
    end else if (wr_fire && hit_strap) begin
      pll_sel_q <= pwdata[bmcc_pkg::PLL_SEL_BIT];
      clk_src_q <= pwdata[bmcc_pkg::CLK_SRC_BIT];
      clk_spd_q <= pwdata[bmcc_pkg::CLK_SPD_LSB +: 3];
    end
  end

  // ****************************************************************
  // cache enable, and clock controls to the pll and output clock generator
  // ****************************************************************
  // the generator itself is analog; here only its selects are steered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      short_term_cache_enable <= 1'b0;
      pll_freq_select         <= 1'b1;
      bus_clock_out_speed     <= bmcc_pkg::SPD_33;
    end else begin
      short_term_cache_enable <= cache_en_q;
      pll_freq_select         <= pll_sel_q;
      if (clk_src_q) begin
        bus_clock_out_speed <= clk_spd_q[1:0];
      end else begin
        bus_clock_out_speed <= speed66_enable_in ? bmcc_pkg::SPD_66
                                                 : bmcc_pkg::SPD_33;
      end
    end
  end

  // ****************************************************************
  // arbiter
  // ****************************************************************
  // index 4 is the bridge's own request; external pins are active low
  bmcc_arbiter #(
    .N        (bmcc_pkg::N_REQ)
  ) u_arb (
    .pclk     (pclk),
    .presetn  (presetn),
    .req      ({internal_request, ~bus_request_in_n}),
    .enable   ({int_arb_en_q, req_arb_en_q}),
    .high_pri ({int_pri_q, req_pri_q}),
    .grant_q  (bus_grant)
  );

  // ****************************************************************
  // completion accumulation
  // ****************************************************************
  logic [bmcc_pkg::CPL_DW_W-1:0] cpl_dw_q;
  logic [bmcc_pkg::CPL_DW_W-1:0] cpl_thresh;
  logic [3:0]                    cpl_code;

  // codes above the last defined one saturate at the largest threshold
  assign cpl_code   = (cpl_cnt_q > bmcc_pkg::CPL_CODE_MAX)
                      ? bmcc_pkg::CPL_CODE_MAX : cpl_cnt_q;
  assign cpl_thresh = bmcc_pkg::CPL_DW_W'((32'(cpl_code) + 1)
                      * bmcc_pkg::CPL_DW_STEP);

  // go rises once enough dwords sit in the buffer, or the read ends short, or at once after start outside pci mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpl_dw_q    <= '0;
      cpl_xfer_go <= 1'b0;
    end else if (cpl_accum_start) begin
      cpl_dw_q    <= '0;
      cpl_xfer_go <= !pci_mode_in;
    end else if (!cpl_xfer_go) begin
      if (cpl_dword_valid) begin
        cpl_dw_q <= cpl_dw_q + 1'b1;
      end
      if ((cpl_dword_valid && (cpl_dw_q + 1'b1 >= cpl_thresh))
          || cpl_last_in || !pci_mode_in) begin
        cpl_xfer_go <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // configuration retry timer
  // ****************************************************************
  bmcc_pkg::bmcc_crt_state_t crt_state_q;
  logic [bmcc_pkg::CRT_W-1:0] crt_cnt_q;
  logic [bmcc_pkg::CRT_W-1:0] crt_limit;

  always_comb begin
    case (crt_sel_q)
      3'h0:    crt_limit = bmcc_pkg::CRT_W'(CRT_CYC_0);
      3'h1:    crt_limit = bmcc_pkg::CRT_W'(CRT_CYC_1);
      3'h2:    crt_limit = bmcc_pkg::CRT_W'(CRT_CYC_2);
      3'h3:    crt_limit = bmcc_pkg::CRT_W'(CRT_CYC_3);
      3'h4:    crt_limit = bmcc_pkg::CRT_W'(CRT_CYC_4);
      3'h5:    crt_limit = bmcc_pkg::CRT_W'(CRT_CYC_5);
      3'h6:    crt_limit = bmcc_pkg::CRT_W'(CRT_CYC_6);
      default: crt_limit = bmcc_pkg::CRT_W'(CRT_CYC_7);
    endcase
  end

  // a completion in the expiry cycle wins, so no CRS follows real data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crt_state_q <= bmcc_pkg::BMCC_CRT_IDLE;
      crt_cnt_q   <= '0;
      crs_return  <= 1'b0;
    end else begin
      crs_return <= 1'b0;
      case (crt_state_q)
        bmcc_pkg::BMCC_CRT_IDLE: begin
          if (cfg1_issue) begin
            crt_state_q <= bmcc_pkg::BMCC_CRT_WAIT;
            crt_cnt_q   <= bmcc_pkg::CRT_W'(1);
          end
        end
        bmcc_pkg::BMCC_CRT_WAIT: begin
          if (cfg1_cpl_in) begin
            crt_state_q <= bmcc_pkg::BMCC_CRT_IDLE;
          end else if (crt_cnt_q >= crt_limit) begin
            crs_return  <= 1'b1;
            crt_state_q <= bmcc_pkg::BMCC_CRT_IDLE;
          end else begin
            crt_cnt_q <= crt_cnt_q + 1'b1;
          end
        end
        default: crt_state_q <= bmcc_pkg::BMCC_CRT_IDLE;
      endcase
    end
  end

endmodule : bmcc_regs

`default_nettype wire

/* bmcc_pkg.sv */
// constants for the bridge misc control and clock strap register bank
// assumes a 100 MHz APB clock and 32-bit APB data

package bmcc_pkg;

  // ****************************************************************
  // bus and timing
  // ****************************************************************
  localparam int unsigned CLK_MHZ      = 100;  // pclk rate
  localparam int unsigned ADDR_W       = 12;
  localparam int unsigned N_REQ        = 5;    // four external + internal
  localparam int unsigned CRT_W        = 20;   // holds 10 ms of cycles

  // ****************************************************************
  // register offsets and reset values
  // ****************************************************************
  localparam logic [11:0] MISC_CSR_OFFSET   = 12'h044;
  localparam logic [11:0] CLK_STRAP_OFFSET  = 12'h048;
  localparam logic [31:0] MISC_CSR_RESET    = 32'h7d10_1900;
  localparam logic [31:0] CLK_STRAP_RESET   = 32'h0000_0100;

  // ****************************************************************
  // misc control/status field positions
  // ****************************************************************
  localparam int unsigned INT_ARB_EN_BIT    = 30;
  localparam int unsigned REQ_ARB_EN_LSB    = 26;  // bits 29:26
  localparam int unsigned PAR_ERR_BIT       = 24;  // read-only, reads 1
  localparam int unsigned CACHE_EN_BIT      = 23;
  localparam int unsigned INT_PRI_BIT       = 20;
  localparam int unsigned REQ_PRI_LSB       = 16;  // bits 19:16
  localparam int unsigned CPL_CNT_LSB       = 11;  // bits 14:11
  localparam int unsigned CPL_CNT_W         = 4;
  localparam int unsigned CRT_LSB           = 8;   // bits 10:8
  localparam int unsigned CRT_SEL_W         = 3;

  // ****************************************************************
  // clock strap field positions
  // ****************************************************************
  localparam int unsigned PLL_SEL_BIT       = 8;
  localparam int unsigned CLK_SRC_BIT       = 3;
  localparam int unsigned CLK_SPD_LSB       = 0;   // bits 2:0, bit 2 unused

  // ****************************************************************
  // completion accumulation
  // ****************************************************************
  localparam int unsigned CPL_DW_STEP       = 8;   // dwords per code step
  localparam logic [3:0]  CPL_CODE_MAX      = 4'h9;
  localparam int unsigned CPL_DW_W          = 7;   // holds 80

  // ****************************************************************
  // configuration retry times in microseconds
  // ****************************************************************
  localparam int unsigned CRT_US_0 = 25;
  localparam int unsigned CRT_US_1 = 40;
  localparam int unsigned CRT_US_2 = 50;
  localparam int unsigned CRT_US_3 = 100;
  localparam int unsigned CRT_US_4 = 200;
  localparam int unsigned CRT_US_5 = 500;
  localparam int unsigned CRT_US_6 = 1000;
  localparam int unsigned CRT_US_7 = 10000;

  // ****************************************************************
  // output clock speed codes
  // ****************************************************************
  localparam logic [1:0] SPD_25  = 2'h0;
  localparam logic [1:0] SPD_33  = 2'h1;
  localparam logic [1:0] SPD_50  = 2'h2;
  localparam logic [1:0] SPD_66  = 2'h3;

  typedef enum logic {
    BMCC_CRT_IDLE,
    BMCC_CRT_WAIT
  } bmcc_crt_state_t;

endpackage : bmcc_pkg

/* bmcc_arbiter.sv */
// two-level round-robin arbiter for the secondary bus
// assumes requests are synchronous, active high, one bit per participant

`timescale 1ns/1ps
`default_nettype none

module bmcc_arbiter #(
  parameter int unsigned N = 5
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [N-1:0] req,
  input  wire logic [N-1:0] enable,
  input  wire logic [N-1:0] high_pri,
  output logic      [N-1:0] grant_q
);

  localparam int unsigned W = $clog2(N);

  logic [N-1:0] grant_d;
  logic [W-1:0] last_q;
  logic [W-1:0] last_d;

  // ****************************************************************
  // selection
  // ****************************************************************
  // holder keeps the bus until it drops or is disabled; no preemption,
  // which avoids cutting a burst short at the cost of some latency
  always_comb begin
    logic [N-1:0] elig;
    logic [N-1:0] pick;
    logic         found;
    int unsigned  idx;
    idx     = 0;
    elig    = req & enable;
    pick    = (|(elig & high_pri)) ? (elig & high_pri)
                                   : (elig & ~high_pri);
    found   = 1'b0;
    grant_d = '0;
    last_d  = last_q;
    if (|(grant_q & elig)) begin
      grant_d = grant_q;
    end else begin
      for (int unsigned k = 1; k <= N; k++) begin
        idx = (32'(last_q) + k) % N;
        if (!found && pick[idx]) begin
          found        = 1'b1;
          grant_d[idx] = 1'b1;
          last_d       = idx[W-1:0];
        end
      end
    end
  end

  // ****************************************************************
  // state
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grant_q <= '0;
      last_q  <= '0;
    end else begin
      grant_q <= grant_d;
      last_q  <= last_d;
    end
  end

endmodule : bmcc_arbiter

`default_nettype wire

/* bmcc_asserts.sv */
// assertions for the misc control and clock strap register bank
// assumes it is bound to bmcc_regs and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module bmcc_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  bus_request_in_n,
  input wire logic        internal_request,
  input wire logic [4:0]  bus_grant,
  input wire logic        pci_mode_in,
  input wire logic        cpl_accum_start,
  input wire logic        cpl_xfer_go,
  input wire logic        cfg1_cpl_in,
  input wire logic        crs_return,
  input wire logic        short_term_cache_enable,
  input wire logic        pll_freq_select,
  input wire logic        speed66_enable_in,
  input wire logic [1:0]  bus_clock_out_speed
);
  // ********
  // strap shadow, so speed checks need no probe into the design
  // ********
  logic       commit;
  logic       unmapped;
  logic       src_q;
  logic [1:0] spd_q;
  assign commit   = psel & penable & pready & pwrite;
  assign unmapped = (paddr != 12'h044) && (paddr != 12'h048);
  // shadow follows each committed strap write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= 1'b0;
      spd_q <= 2'h0;
    end else if (commit && paddr == 12'h048) begin
      src_q <= pwdata[3];
      spd_q <= pwdata[1:0];
    end
  end
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ********
  // properties
  // ********
  ready_wait_a: assert property (psel && !penable && !pready |=> pready)
    else $error("apb access phase without ready");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  map_err_a: assert property (
    psel && !penable |=> pslverr == $past(unmapped))
    else $error("slave error does not match address map");
  stc_copy_a: assert property (commit && paddr == 12'h044 |-> ##2
    short_term_cache_enable == $past(pwdata[23], 2)) else $error("cache bit");
  pll_copy_a: assert property (commit && paddr == 12'h048 |-> ##2
    pll_freq_select == $past(pwdata[8], 2)) else $error("pll select bit");
  speed_pin_a: assert property (!src_q |=>
    bus_clock_out_speed == {$past(speed66_enable_in), 1'b1})
    else $error("speed does not follow the 66 pin");
  speed_sel_a: assert property (
    src_q |=> bus_clock_out_speed == $past(spd_q))
    else $error("speed does not follow the speed field");
  grant_hot_a: assert property ($onehot0(bus_grant))
    else $error("more than one grant");
  grant_req_a: assert property ((bus_grant & ~{$past(internal_request),
    ~$past(bus_request_in_n)}) == 5'h00) else $error("grant without request");
  crs_pulse_a: assert property (crs_return |=> !crs_return)
    else $error("retry status held too long");
  crs_cpl_a: assert property (cfg1_cpl_in |=> !crs_return)
    else $error("retry status after completion");
  go_clear_a: assert property (
    cpl_accum_start && pci_mode_in |=> !cpl_xfer_go)
    else $error("transfer go not cleared by start");
  go_hold_a: assert property (
    cpl_xfer_go && !cpl_accum_start |=> cpl_xfer_go)
    else $error("transfer go dropped early");
  crs_seen_c: cover property (crs_return);
  go_seen_c: cover property ($rose(cpl_xfer_go));
  err_seen_c: cover property (pready && pslverr);
endmodule : bmcc_asserts

bind bmcc_regs bmcc_asserts u_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .bus_request_in_n(bus_request_in_n),
  .internal_request(internal_request), .bus_grant(bus_grant),
  .pci_mode_in(pci_mode_in), .cpl_accum_start(cpl_accum_start),
  .cpl_xfer_go(cpl_xfer_go), .cfg1_cpl_in(cfg1_cpl_in),
  .crs_return(crs_return), .short_term_cache_enable(short_term_cache_enable),
  .pll_freq_select(pll_freq_select), .speed66_enable_in(speed66_enable_in),
  .bus_clock_out_speed(bus_clock_out_speed));
`default_nettype wire

/* tb.sv */
// self-checking bench for the misc control and clock strap register bank
// assumes bmcc_regs with shortened retry limits of 20 plus 10 per code
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int unsigned CB = 20;  // retry limit of code 0
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [3:0]  bus_request_in_n;
  logic [4:0]  bus_grant;
  logic [1:0]  bus_clock_out_speed;
  logic        internal_request, pci_mode_in, cpl_accum_start, cpl_xfer_go;
  logic        cpl_dword_valid, cpl_last_in, cfg1_issue, cfg1_cpl_in;
  logic        crs_return, short_term_cache_enable, pll_freq_select;
  logic        speed66_enable_in;
  logic [32:0] rq[$];
  int          err_total, total_checks, cyc, n;
  bmcc_regs #(.CRT_CYC_0(CB), .CRT_CYC_1(CB+10), .CRT_CYC_2(CB+20),
    .CRT_CYC_3(CB+30), .CRT_CYC_4(CB+40), .CRT_CYC_5(CB+50),
    .CRT_CYC_6(CB+60), .CRT_CYC_7(CB+70)) dut (.*);
  // ********
  // clock, timeout and common tasks
  // ********
  always #5 pclk = ~pclk;
  // cut a hang short well past the longest expected run
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask : tick
  // one apb transfer; holds the request until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd, input logic [32:0] e);
    @(posedge pclk);
    rq.push_back(e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait-state count assumed; only the bench timeout ends a hang
    do begin
      @(posedge pclk);
    end while (!pready);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, {1'b0, e});
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd, 33'h0_0000_0000);
  endtask : wr
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // result watcher: each completed transfer takes the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      if (rq.size() == 0) check(33'h1_0000_0000, 33'h0);
      else if (pwrite) check({pslverr, 32'h0}, {rq.pop_front() & 33'h1_0000_0000});
      else check({pslverr, prdata}, rq.pop_front());
    end
  end
  // ********
  // main sequence
  // ********
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {internal_request, pci_mode_in, cpl_accum_start, cpl_dword_valid} = '0;
    {cpl_last_in, cfg1_issue, cfg1_cpl_in, speed66_enable_in} = '0;
    bus_request_in_n = 4'hf;
    void'($urandom(38637));
    tick(10);
    presetn <= 1'b1;
    rd(12'h044, 32'h7d10_1900);
    rd(12'h048, 32'h0000_0100);
    check(pll_freq_select, 1'b1);
    $display("test reset values done");
    // all ones, all zeros, then random words; reserved bits stay zero
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : $urandom();
      wr(12'h044, d);
      rd(12'h044, (d & 32'h7c9f_7f00) | 32'h0100_0000);
      check(short_term_cache_enable, d[23]);
      d = (i == 1) ? d : d | 32'h0000_0100;
      wr(12'h048, d);
      rd(12'h048, d & 32'h0000_010f);
      tick(1);
      check(pll_freq_select, d[8]);
    end
    apb(1'b1, 12'h04c, 32'hffff_ffff, {1'b1, 32'h0});
    apb(1'b0, 12'h04c, 32'h0, {1'b1, 32'h0});
    $display("test register access done");
    wr(12'h048, 32'h0000_0100);
    for (int p = 0; p < 2; p++) begin
      speed66_enable_in <= p[0];
      tick(3);
      check(bus_clock_out_speed, p[0] ? 2'h3 : 2'h1);
    end
    for (int s = 0; s < 8; s++) begin
      speed66_enable_in <= 1'($urandom());
      wr(12'h048, 32'h0000_0108 | s);
      tick(3);
      check(bus_clock_out_speed, s[1:0]);
    end
    $display("test clock speed done");
    // every threshold code: one dword short holds, the next releases
    pci_mode_in <= 1'b1;
    for (int c = 0; c < 10; c++) begin
      wr(12'h044, 32'h7c10_0100 | (c << 11));
      cpl_accum_start <= 1'b1;
      tick(1);
      cpl_accum_start <= 1'b0;
      cpl_dword_valid <= 1'b1;
      tick((c + 1) * 8 - 1);
      cpl_dword_valid <= 1'b0;
      tick(2);
      check(cpl_xfer_go, 1'b0);
      cpl_dword_valid <= 1'b1;
      tick(1);
      cpl_dword_valid <= 1'b0;
      tick(2);
      check(cpl_xfer_go, 1'b1);
    end
    for (int m = 0; m < 2; m++) begin
      pci_mode_in     <= m[0];
      cpl_accum_start <= 1'b1;
      tick(1);
      cpl_accum_start <= 1'b0;
      cpl_last_in     <= m[0];
      tick(1);
      cpl_last_in     <= 1'b0;
      tick(2);
      check(cpl_xfer_go, 1'b1);
    end
    $display("test accumulation done");
    // each timer code, then a completion that beats the timer
    for (int c = 0; c < 9; c++) begin
      wr(12'h044, 32'h7c10_1800 | ((c % 8) << 8));
      cfg1_issue <= 1'b1;
      tick(1);
      cfg1_issue <= 1'b0;
      if (c == 8) begin
        tick(5);
        cfg1_cpl_in <= 1'b1;
        tick(1);
        cfg1_cpl_in <= 1'b0;
      end
      n = 0;
      do begin
        tick(1);
        n++;
      end while (!crs_return && n < 120);
      check(n, (c == 8) ? 120 : CB + 10 * c + 1);
    end
    $display("test retry timer done");
    // priority group wins, disabled requester never granted
    for (int k = 0; k < 4; k++) begin
      bus_request_in_n <= 4'hf;
      internal_request <= 1'b0;
      tick(3);
      wr(12'h044, (k == 0) ? 32'h7c04_1900 : (k == 1) ? 32'h6c04_1900
                                                      : 32'h7c10_1900);
      bus_request_in_n <= (k == 0) ? 4'h0 : (k == 1) ? 4'h9 : 4'he;
      internal_request <= (k != 1) && (k != 3);
      tick(3);
      check(bus_grant, (k == 0) ? 5'h04 : (k == 1) ? 5'h02 : (k == 2) ? 5'h10
                                                             : 5'h01);
    end
    $display("test arbitration done");
    tick(3);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
